// *** hdl/toc_pkg.sv ***
// Constants, register offsets and modes for the 16-bit timer compare block
package toc_pkg;

    localparam int TOC_AW = 4;

    // Register offsets on the byte-wide port
    localparam logic [3:0] TOC_OFS_CTRL_A = 4'h0;
    localparam logic [3:0] TOC_OFS_CTRL_B = 4'h1;
    localparam logic [3:0] TOC_OFS_FORCE = 4'h2;
    localparam logic [3:0] TOC_OFS_CNT_L = 4'h3;
    localparam logic [3:0] TOC_OFS_CNT_H = 4'h4;
    localparam logic [3:0] TOC_OFS_CMPA_L = 4'h5;
    localparam logic [3:0] TOC_OFS_CMPA_H = 4'h6;
    localparam logic [3:0] TOC_OFS_CMPB_L = 4'h7;
    localparam logic [3:0] TOC_OFS_CMPB_H = 4'h8;
    localparam logic [3:0] TOC_OFS_CAPT_L = 4'h9;
    localparam logic [3:0] TOC_OFS_CAPT_H = 4'hA;
    localparam logic [3:0] TOC_OFS_IRQ_EN = 4'hB;
    localparam logic [3:0] TOC_OFS_FLAGS = 4'hC;

    // Field positions
    localparam int TOC_POS_COM_A = 6;
    localparam int TOC_POS_COM_B = 4;
    localparam int TOC_POS_WGM_LO = 0;
    localparam int TOC_POS_WGM_HI = 3;
    localparam int TOC_POS_FORCE_A = 7;
    localparam int TOC_POS_FORCE_B = 6;
    localparam int TOC_POS_OVF = 0;
    localparam int TOC_POS_FLAG_A = 1;
    localparam int TOC_POS_FLAG_B = 2;

    // Counter limits and fixed TOP values
    localparam logic [15:0] TOC_CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOC_CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] TOC_TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOC_TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOC_TOP_10BIT = 16'h03FF;

    // Reset values
    localparam logic [15:0] TOC_RST_WORD = 16'h0000;
    localparam logic [7:0] TOC_RST_BYTE = 8'h00;
    localparam logic [3:0] TOC_RST_WGM = 4'h0;
    localparam logic [1:0] TOC_RST_COM = 2'h0;

    // Output mode codes
    localparam logic [1:0] TOC_COM_OFF = 2'h0;
    localparam logic [1:0] TOC_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TOC_COM_CLEAR = 2'h2;
    localparam logic [1:0] TOC_COM_SET = 2'h3;

    typedef enum logic [1:0] {
        TOC_DIR_UP = 2'b01,
        TOC_DIR_DOWN = 2'b10
    } toc_dir_e;

endpackage : toc_pkg

// *** hdl/toc_timer16_compare.sv ***
// Two-channel output compare unit with its 16-bit counter and byte-wide register port
`timescale 1ns/100ps
module toc_timer16_compare
    import toc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Timer clock enable from the prescaler, one cycle long
    input wire logic timer_tick,
    // Register port
    input wire logic [TOC_AW-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Interrupt service acknowledges
    input wire logic irq_ack_a,
    input wire logic irq_ack_b,
    input wire logic irq_ack_ovf,
    // Interrupt requests
    output logic irq_req_a,
    output logic irq_req_b,
    output logic irq_req_ovf,
    // General port values and direction bits
    input wire logic port_data_a,
    input wire logic port_data_b,
    input wire logic output_pin_direction_bit_a,
    input wire logic output_pin_direction_bit_b,
    // Pins
    output logic compare_output_a,
    output logic compare_output_a_oe,
    output logic compare_output_b,
    output logic compare_output_b_oe
);

    function automatic logic mode_is_pwm(input logic [3:0] m);
        mode_is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
    endfunction

    function automatic logic mode_is_dual(input logic [3:0] m);
        mode_is_dual = (m == 4'h1 || m == 4'h2 || m == 4'h3 || m == 4'h8 ||
            m == 4'h9 || m == 4'hA || m == 4'hB);
    endfunction

    function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp_a,
        input logic [15:0] capt);
        case (m)
            4'h1, 4'h5: top_of = TOC_TOP_8BIT;
            4'h2, 4'h6: top_of = TOC_TOP_9BIT;
            4'h3, 4'h7: top_of = TOC_TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_of = cmp_a;
            4'h8, 4'hA, 4'hC, 4'hE: top_of = capt;
            default: top_of = TOC_CNT_MAX;
        endcase
    endfunction

    // Control state
    logic [3:0] wgm_q;
    logic [1:0] com_q [2];
    logic [2:0] irq_en_q;
    logic [2:0] flags_q;
    logic [7:0] temp_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] capt_q;
    logic [15:0] cmp_act_q [2];
    logic [15:0] cmp_buf_q [2];
    logic [1:0] oc_q;
    logic blk_q;
    toc_dir_e dir_q;
    toc_dir_e dir_d;

    logic pwm;
    logic dual;
    logic [15:0] top;
    logic top_hit;
    logic ovf_set;
    logic buf_upd;
    logic fast_bottom;
    logic [1:0] match;
    logic [1:0] force_cmp;
    logic [1:0] w1c;

    // Port decode
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_force;
    logic wr_cnt_l;
    logic wr_capt_l;
    logic wr_any_high;
    logic wr_irq_en;
    logic wr_flags;
    logic [1:0] wr_cmp_l;

    assign wr_ctrl_a = reg_wr && reg_addr == TOC_OFS_CTRL_A;
    assign wr_ctrl_b = reg_wr && reg_addr == TOC_OFS_CTRL_B;
    assign wr_force = reg_wr && reg_addr == TOC_OFS_FORCE;
    assign wr_cnt_l = reg_wr && reg_addr == TOC_OFS_CNT_L;
    assign wr_capt_l = reg_wr && reg_addr == TOC_OFS_CAPT_L;
    assign wr_cmp_l[0] = reg_wr && reg_addr == TOC_OFS_CMPA_L;
    assign wr_cmp_l[1] = reg_wr && reg_addr == TOC_OFS_CMPB_L;
    assign wr_irq_en = reg_wr && reg_addr == TOC_OFS_IRQ_EN;
    assign wr_flags = reg_wr && reg_addr == TOC_OFS_FLAGS;
    assign wr_any_high = reg_wr && (reg_addr == TOC_OFS_CNT_H || reg_addr == TOC_OFS_CMPA_H ||
        reg_addr == TOC_OFS_CMPB_H || reg_addr == TOC_OFS_CAPT_H);

    assign pwm = mode_is_pwm(wgm_q);
    assign dual = mode_is_dual(wgm_q);
    assign top = top_of(wgm_q, cmp_act_q[0], capt_q);
    // Blocked TOP match lets the counter run on to MAX
    assign top_hit = cnt_q == top && !blk_q;

    // Compare matches only count on a timer tick, and never while matches are blocked
    assign match[0] = timer_tick && cnt_q == cmp_act_q[0] && !blk_q;
    assign match[1] = timer_tick && cnt_q == cmp_act_q[1] && !blk_q;

    // Forcing is ignored in PWM modes
    assign force_cmp[0] = wr_force && reg_wdata[TOC_POS_FORCE_A] && !pwm;
    assign force_cmp[1] = wr_force && reg_wdata[TOC_POS_FORCE_B] && !pwm;
    assign w1c[0] = wr_flags && reg_wdata[TOC_POS_FLAG_A];
    assign w1c[1] = wr_flags && reg_wdata[TOC_POS_FLAG_B];

    // Counting sequence depends on the waveform mode, its TOP value and the match block
    always_comb begin
        cnt_d = cnt_q + 16'h0001;
        dir_d = dir_q;
        ovf_set = 1'b0;
        buf_upd = 1'b0;
        fast_bottom = 1'b0;
        if (dual) begin
            if (dir_q == TOC_DIR_UP) begin
                if (top_hit) begin
                    dir_d = TOC_DIR_DOWN;
                    cnt_d = cnt_q - 16'h0001;
                    buf_upd = !(wgm_q == 4'h8 || wgm_q == 4'h9);
                end
            end else begin
                if (cnt_q == TOC_CNT_BOTTOM) begin
                    dir_d = TOC_DIR_UP;
                    ovf_set = 1'b1;
                    buf_upd = wgm_q == 4'h8 || wgm_q == 4'h9;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
        end else if (pwm) begin
            if (top_hit) begin
                cnt_d = TOC_CNT_BOTTOM;
                ovf_set = 1'b1;
                buf_upd = 1'b1;
                fast_bottom = 1'b1;
            end
        end else begin
            // Normal wraps at MAX; clear-on-match clears at its TOP
            if (top_hit) begin
                cnt_d = TOC_CNT_BOTTOM;
            end
            ovf_set = cnt_q == TOC_CNT_MAX;
        end
    end

    // Counter: CPU write outranks counting, accepted in any mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= TOC_RST_WORD;
            dir_q <= TOC_DIR_UP;
        end else if (wr_cnt_l) begin
            cnt_q <= {temp_q, reg_wdata};
        end else if (timer_tick) begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // Match block holds from a counter write until the next tick passes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blk_q <= 1'b0;
        end else if (wr_cnt_l) begin
            blk_q <= 1'b1;
        end else if (timer_tick) begin
            blk_q <= 1'b0;
        end
    end

    // Shared high-byte latch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            temp_q <= TOC_RST_BYTE;
        end else if (wr_any_high) begin
            temp_q <= reg_wdata;
        end else if (reg_rd && reg_addr == TOC_OFS_CNT_L) begin
            temp_q <= cnt_q[15:8];
        end else if (reg_rd && reg_addr == TOC_OFS_CAPT_L) begin
            temp_q <= capt_q[15:8];
        end
    end

    // Compare registers: CPU writes fill the buffer, and the active value outside PWM; PWM loads it from the buffer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 2; i++) begin
                cmp_act_q[i] <= TOC_RST_WORD;
                cmp_buf_q[i] <= TOC_RST_WORD;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_cmp_l[i]) begin
                    cmp_buf_q[i] <= {temp_q, reg_wdata};
                    if (!pwm) begin
                        cmp_act_q[i] <= {temp_q, reg_wdata};
                    end
                end
                if (pwm && timer_tick && buf_upd && !wr_cnt_l) begin
                    cmp_act_q[i] <= cmp_buf_q[i];
                end
            end
        end
    end

    // Capture register, writable only where it defines TOP
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            capt_q <= TOC_RST_WORD;
        end else if (wr_capt_l && (wgm_q == 4'h8 || wgm_q == 4'hA || wgm_q == 4'hC ||
            wgm_q == 4'hE)) begin
            capt_q <= {temp_q, reg_wdata};
        end
    end

    // Mode and enable registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wgm_q <= TOC_RST_WGM;
            com_q[0] <= TOC_RST_COM;
            com_q[1] <= TOC_RST_COM;
            irq_en_q <= 3'h0;
        end else begin
            if (wr_ctrl_a) begin
                // Output mode is not buffered and applies at once
                com_q[0] <= reg_wdata[TOC_POS_COM_A+:2];
                com_q[1] <= reg_wdata[TOC_POS_COM_B+:2];
                wgm_q[1:0] <= reg_wdata[TOC_POS_WGM_LO+:2];
            end
            if (wr_ctrl_b) begin
                wgm_q[3:2] <= reg_wdata[TOC_POS_WGM_HI+:2];
            end
            if (wr_irq_en) begin
                irq_en_q <= reg_wdata[2:0];
            end
        end
    end

    // Flags: a setting event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= 3'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (match[i]) begin
                    flags_q[TOC_POS_FLAG_A+i] <= 1'b1;
                end else if (w1c[i] || (i == 0 ? irq_ack_a : irq_ack_b)) begin
                    flags_q[TOC_POS_FLAG_A+i] <= 1'b0;
                end
            end
            if (timer_tick && !wr_cnt_l && ovf_set) begin
                flags_q[TOC_POS_OVF] <= 1'b1;
            end else if (irq_ack_ovf || (wr_flags && reg_wdata[TOC_POS_OVF])) begin
                flags_q[TOC_POS_OVF] <= 1'b0;
            end
        end
    end

    assign irq_req_a = flags_q[TOC_POS_FLAG_A] && irq_en_q[TOC_POS_FLAG_A];
    assign irq_req_b = flags_q[TOC_POS_FLAG_B] && irq_en_q[TOC_POS_FLAG_B];
    assign irq_req_ovf = flags_q[TOC_POS_OVF] && irq_en_q[TOC_POS_OVF];

    // Output registers survive mode changes; reset and the compare actions change them, not a mode write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oc_q <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (com_q[i] == TOC_COM_OFF) begin
                    oc_q[i] <= oc_q[i];
                end else if (!pwm) begin
                    if (match[i] || force_cmp[i]) begin
                        case (com_q[i])
                            TOC_COM_TOGGLE: oc_q[i] <= !oc_q[i];
                            TOC_COM_CLEAR: oc_q[i] <= 1'b0;
                            default: oc_q[i] <= 1'b1;
                        endcase
                    end
                end else if (com_q[i] != TOC_COM_TOGGLE) begin
                    if (match[i]) begin
                        // Upcount match acts like the single-slope match
                        oc_q[i] <= (com_q[i] == TOC_COM_SET) ^
                            (dual && dir_q == TOC_DIR_DOWN);
                    end else if (fast_bottom && timer_tick && !wr_cnt_l) begin
                        oc_q[i] <= com_q[i] == TOC_COM_CLEAR;
                    end
                end
            end
        end
    end

    // Pins: waveform overrides port data, direction stays with the port
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            compare_output_a <= 1'b0;
            compare_output_b <= 1'b0;
            compare_output_a_oe <= 1'b0;
            compare_output_b_oe <= 1'b0;
        end else begin
            compare_output_a <= com_q[0] != TOC_COM_OFF ? oc_q[0] : port_data_a;
            compare_output_b <= com_q[1] != TOC_COM_OFF ? oc_q[1] : port_data_b;
            compare_output_a_oe <= output_pin_direction_bit_a;
            compare_output_b_oe <= output_pin_direction_bit_b;
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= TOC_RST_BYTE;
        end else if (!reg_rd) begin
            reg_rdata <= TOC_RST_BYTE;
        end else if (reg_addr == TOC_OFS_CTRL_A) begin
            reg_rdata <= {com_q[0], com_q[1], 2'b00, wgm_q[1:0]};
        end else if (reg_addr == TOC_OFS_CTRL_B) begin
            reg_rdata <= {3'b000, wgm_q[3:2], 3'b000};
        end else if (reg_addr == TOC_OFS_CNT_L) begin
            reg_rdata <= cnt_q[7:0];
        end else if (reg_addr == TOC_OFS_CNT_H || reg_addr == TOC_OFS_CAPT_H) begin
            reg_rdata <= temp_q;
        end else if (reg_addr == TOC_OFS_CMPA_L) begin
            reg_rdata <= cmp_buf_q[0][7:0];
        end else if (reg_addr == TOC_OFS_CMPA_H) begin
            reg_rdata <= cmp_buf_q[0][15:8];
        end else if (reg_addr == TOC_OFS_CMPB_L) begin
            reg_rdata <= cmp_buf_q[1][7:0];
        end else if (reg_addr == TOC_OFS_CMPB_H) begin
            reg_rdata <= cmp_buf_q[1][15:8];
        end else if (reg_addr == TOC_OFS_CAPT_L) begin
            reg_rdata <= capt_q[7:0];
        end else if (reg_addr == TOC_OFS_IRQ_EN) begin
            reg_rdata <= {5'b00000, irq_en_q};
        end else if (reg_addr == TOC_OFS_FLAGS) begin
            reg_rdata <= {5'b00000, flags_q};
        end else begin
            reg_rdata <= TOC_RST_BYTE;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence high_a_s;
        reg_wr && reg_addr == TOC_OFS_CMPA_H;
    endsequence

    sequence low_a_direct_s;
        reg_wr && reg_addr == TOC_OFS_CMPA_L && !pwm;
    endsequence

    flag_set_a: assert property (match[0] |=> flags_q[TOC_POS_FLAG_A])
        else $error("compare flag A not set after match");

    flag_clear_a: assert property (w1c[0] && !match[0] |=> !flags_q[TOC_POS_FLAG_A])
        else $error("compare flag A not cleared by written one");

    word_write_a: assert property (high_a_s ##1 low_a_direct_s
        |=> cmp_act_q[0] == {$past(reg_wdata, 2), $past(reg_wdata)})
        else $error("compare A word write lost a byte");

    block_match_a: assert property ($rose(flags_q[TOC_POS_FLAG_A])
        |-> $past(timer_tick && !blk_q))
        else $error("compare flag A set while matches blocked");

    force_action_a: assert property (force_cmp[0] && com_q[0] == TOC_COM_TOGGLE &&
        !match[0] |=> oc_q[0] != $past(oc_q[0]) && $stable(cnt_q) ||
        $past(timer_tick || wr_cnt_l))
        else $error("force strobe did not toggle output A");

    hold_off_a: assert property (com_q[0] == TOC_COM_OFF |=> $stable(oc_q[0]))
        else $error("output A changed with mode zero");

    pin_override_a: assert property (com_q[0] != TOC_COM_OFF
        |=> compare_output_a == $past(oc_q[0]))
        else $error("pin A not driven from output register");

    high_read_a: assert property (reg_rd && reg_addr == TOC_OFS_CMPA_H
        |=> reg_rdata == $past(cmp_buf_q[0][15:8]))
        else $error("compare A high read not direct");

    normal_wrap_a: assert property (timer_tick && !wr_cnt_l && wgm_q == 4'h0 &&
        cnt_q == TOC_CNT_MAX |=> cnt_q == TOC_CNT_BOTTOM && flags_q[TOC_POS_OVF])
        else $error("normal mode wrap or overflow flag wrong");

endmodule // toc_timer16_compare

// *** tb/tb.sv ***
// Self-checking bench for the two-channel timer compare block
`timescale 1ns/100ps
module tb;
    import toc_pkg::*;

    logic clk, rstn, timer_tick, reg_wr, reg_rd;
    logic [TOC_AW-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    logic irq_ack_a, irq_ack_b, irq_ack_ovf, irq_req_a, irq_req_b, irq_req_ovf;
    logic port_data_a, port_data_b, dir_a, dir_b;
    logic oc_a, oc_a_oe, oc_b, oc_b_oe;
    int error_cnt, samples_checked, cycles, i;
    // Row: write flag, offset, write data, expected read data
    logic [20:0] rows [0:12] = '{
        {1'b1, TOC_OFS_CMPA_H, 8'h12, 8'h00}, {1'b1, TOC_OFS_CMPA_L, 8'h34, 8'h00},
        {1'b0, TOC_OFS_CMPA_L, 8'h00, 8'h34}, {1'b0, TOC_OFS_CMPA_H, 8'h00, 8'h12},
        {1'b1, TOC_OFS_CMPB_H, 8'hAB, 8'h00}, {1'b1, TOC_OFS_CMPB_L, 8'hCD, 8'h00},
        {1'b0, TOC_OFS_CMPB_L, 8'h00, 8'hCD}, {1'b0, TOC_OFS_CMPB_H, 8'h00, 8'hAB},
        // Counter high byte fills the shared latch only
        {1'b1, TOC_OFS_CNT_H, 8'h56, 8'h00}, {1'b0, TOC_OFS_CMPA_H, 8'h00, 8'h12},
        {1'b1, TOC_OFS_CMPA_L, 8'h78, 8'h00}, {1'b0, TOC_OFS_CMPA_H, 8'h00, 8'h56},
        {1'b0, 4'hF, 8'h00, 8'h00}};
    // Output mode and expected pin after a forced compare
    logic [2:0] frc [0:4] = '{3'b111, 3'b100, 3'b011, 3'b010, 3'b001};

    toc_timer16_compare u_toc_timer16_compare (
        .clk(clk), .rstn(rstn), .timer_tick(timer_tick),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b), .irq_ack_ovf(irq_ack_ovf),
        .irq_req_a(irq_req_a), .irq_req_b(irq_req_b), .irq_req_ovf(irq_req_ovf),
        .port_data_a(port_data_a), .port_data_b(port_data_b),
        .output_pin_direction_bit_a(dir_a), .output_pin_direction_bit_b(dir_b),
        .compare_output_a(oc_a), .compare_output_a_oe(oc_a_oe),
        .compare_output_b(oc_b), .compare_output_b_oe(oc_b_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd8(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    // High byte first, low offset sits just below the high one; no gap between bytes
    task automatic wr16(input logic [3:0] a_hi, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a_hi;
        reg_wdata <= v[15:8];
        @(posedge clk);
        reg_addr <= a_hi - 4'h1;
        reg_wdata <= v[7:0];
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic tick();
        @(posedge clk);
        timer_tick <= 1'b1;
        @(posedge clk);
        timer_tick <= 1'b0;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask,
                        input string what);
        samples_checked++;
        if ((got & mask) !== (exp & mask)) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            $display("unexpected at %0t: run did not finish", $time);
            wrap_up();
        end
    end

    initial begin
        {rstn, timer_tick, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {irq_ack_a, irq_ack_b, irq_ack_ovf, port_data_b, dir_a, dir_b} = '0;
        port_data_a = 1'b1;
        repeat (15) @(posedge clk);
        #1 cmp8({4'h0, oc_a, oc_a_oe, irq_req_a, irq_req_ovf}, 8'h00, 8'h0F, "reset");
        @(posedge clk);
        rstn <= 1'b1;
        $display("test reset done");
        for (i = 0; i < 13; i++) begin
            if (rows[i][20]) begin
                wr8(rows[i][19:16], rows[i][15:8]);
            end else begin
                rd8(rows[i][19:16]);
                cmp8(rd_val, rows[i][7:0], 8'hFF, "register row");
            end
        end
        $display("test register rows done");
        wr8(TOC_OFS_IRQ_EN, 8'h07);
        wr16(TOC_OFS_CNT_H, 16'hFFFF);
        tick();
        rd8(TOC_OFS_CNT_L);
        cmp8(rd_val, 8'h00, 8'hFF, "count low after wrap");
        rd8(TOC_OFS_CNT_H);
        cmp8(rd_val, 8'h00, 8'hFF, "count high after wrap");
        rd8(TOC_OFS_FLAGS);
        cmp8(rd_val, 8'h01, 8'h01, "overflow flag");
        cmp8({7'h0, irq_req_ovf}, 8'h01, 8'h01, "overflow request");
        @(posedge clk);
        irq_ack_ovf <= 1'b1;
        @(posedge clk);
        irq_ack_ovf <= 1'b0;
        #1 cmp8({7'h0, irq_req_ovf}, 8'h00, 8'h01, "overflow ack");
        $display("test overflow done");
        wr16(TOC_OFS_CMPA_H, 16'h0005);
        wr16(TOC_OFS_CNT_H, 16'h0005);
        tick();
        rd8(TOC_OFS_FLAGS);
        cmp8(rd_val, 8'h00, 8'h02, "blocked match");
        wr16(TOC_OFS_CNT_H, 16'h0004);
        tick();
        tick();
        #1 cmp8({7'h0, irq_req_a}, 8'h01, 8'h01, "match request");
        @(posedge clk);
        irq_ack_a <= 1'b1;
        @(posedge clk);
        irq_ack_a <= 1'b0;
        #1 cmp8({7'h0, irq_req_a}, 8'h00, 8'h01, "match ack");
        wr16(TOC_OFS_CNT_H, 16'h0004);
        tick();
        tick();
        wr8(TOC_OFS_FLAGS, 8'h02);
        #1 cmp8({7'h0, irq_req_a}, 8'h00, 8'h01, "flag write one");
        $display("test match done");
        // Output state is set up while the pin is still an input
        wr8(TOC_OFS_CTRL_A, 8'hC0);
        wr8(TOC_OFS_FORCE, 8'h80);
        repeat (2) @(posedge clk);
        #1 cmp8({6'h0, oc_a_oe, oc_a}, 8'h01, 8'h03, "set up before drive");
        @(posedge clk);
        dir_a <= 1'b1;
        for (i = 0; i < 5; i++) begin
            wr8(TOC_OFS_CTRL_A, {frc[i][2:1], 6'h00});
            wr8(TOC_OFS_FORCE, 8'h80);
            repeat (2) @(posedge clk);
            #1 cmp8({6'h0, oc_a_oe, oc_a}, {6'h0, 1'b1, frc[i][0]}, 8'h03, "forced pin");
        end
        // Mode zero force must have left the output register low
        wr8(TOC_OFS_CTRL_A, 8'hC0);
        repeat (2) @(posedge clk);
        #1 cmp8({7'h0, oc_a}, 8'h00, 8'h01, "held output");
        cmp8({7'h0, oc_b_oe}, 8'h00, 8'h01, "pin b direction");
        rd8(TOC_OFS_FLAGS);
        cmp8(rd_val, 8'h00, 8'h02, "force leaves flag");
        $display("test force done");
        // Clear on match with channel A, toggle output
        wr8(TOC_OFS_CTRL_B, 8'h08);
        wr8(TOC_OFS_CTRL_A, 8'h40);
        wr16(TOC_OFS_CMPA_H, 16'h0002);
        wr16(TOC_OFS_CMPB_H, 16'h0001);
        wr16(TOC_OFS_CNT_H, 16'h0000);
        tick();
        tick();
        #1 cmp8({6'h0, irq_req_b, irq_req_a}, 8'h02, 8'h03, "match b only");
        tick();
        rd8(TOC_OFS_CNT_L);
        cmp8(rd_val, 8'h00, 8'hFF, "clear at compare a");
        cmp8({6'h0, irq_req_a, oc_a}, 8'h03, 8'h03, "toggle at match a");
        $display("test clear on match done");
        // Fast PWM with channel A as TOP, channel B non-inverted
        wr8(TOC_OFS_FLAGS, 8'h07);
        wr8(TOC_OFS_CTRL_B, 8'h18);
        wr8(TOC_OFS_CTRL_A, 8'h23);
        wr16(TOC_OFS_CMPA_H, 16'h0004);
        rd8(TOC_OFS_CMPA_L);
        cmp8(rd_val, 8'h04, 8'hFF, "buffer read back");
        wr16(TOC_OFS_CNT_H, 16'h0001);
        tick();
        tick();
        rd8(TOC_OFS_CNT_L);
        cmp8(rd_val, 8'h00, 8'hFF, "old top still active");
        cmp8({7'h0, oc_b}, 8'h01, 8'h01, "set at bottom");
        repeat (3) tick();
        rd8(TOC_OFS_CNT_L);
        cmp8(rd_val, 8'h03, 8'hFF, "new top from buffer");
        cmp8({7'h0, oc_b}, 8'h00, 8'h01, "clear at match");
        wr16(TOC_OFS_CNT_H, 16'h0004);
        tick();
        rd8(TOC_OFS_CNT_L);
        cmp8(rd_val, 8'h05, 8'hFF, "written top skipped");
        $display("test fast pwm done");
        wrap_up();
    end
endmodule // tb
